// ### hdl/pbmc_top.sv
// Basic mode control register of one PHY port with its management slave.
// Assumes MDC, MDIO, straps and pins are asynchronous and MDC is well
// below a quarter of core_clk; the negotiation engine shares core_clk.
`timescale 1ns/1ps
module pbmc_top
    import pbmc_pkg::*;
(
    input  wire logic       core_clk,               // 125 MHz core clock
    input  wire logic       rst,                    // Synchronous reset, active high
    input  wire logic       mdc,                    // Management clock pin
    input  wire logic       mdio_i,                 // Management data in
    output logic            mdio_o,                 // Management data out
    output logic            mdio_oe,                // Management data drive enable
    input  wire logic [4:0] phy_addr_pin,           // Port address straps
    input  wire logic       an_enable_strap,        // Auto-negotiation enable strap
    input  wire logic       speed_strap,            // Speed strap
    input  wire logic       duplex_strap,           // Duplex strap
    input  wire logic       fiber_mode_enable,      // Fiber mode pin
    input  wire logic       power_down_input_pin_n, // Power-down pin, active low
    input  wire logic       tx_en,                  // MII transmit enable
    output logic            col,                    // MII collision
    input  wire logic       an_speed_100,           // Negotiated speed
    input  wire logic       an_full_duplex,         // Negotiated duplex
    input  wire logic       an_started,             // Negotiation restarted pulse
    output pbmc_mode_t      mode                    // Port operating mode
);

    logic [12:0] pins_s;
    logic        mdc_s;
    logic        mdio_s;
    logic [4:0]  phy_addr_s;
    logic        an_strap_s;
    logic        spd_strap_s;
    logic        dup_strap_s;
    logic        fiber_s;
    logic        pd_n_s;
    logic        tx_en_s;

    pbmc_sync #(.W(13)) u_sync (
        .core_clk (core_clk),
        .d        ({mdc, mdio_i, phy_addr_pin, an_enable_strap, speed_strap,
                    duplex_strap, fiber_mode_enable, power_down_input_pin_n, tx_en}),
        .q        (pins_s)
    );

    assign {mdc_s, mdio_s, phy_addr_s, an_strap_s, spd_strap_s,
            dup_strap_s, fiber_s, pd_n_s, tx_en_s} = pins_s;

    logic mdc_prev_q;
    logic mdc_rise;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            mdc_prev_q <= 1'b0;
        end else begin
            mdc_prev_q <= mdc_s;
        end
    end

    assign mdc_rise = mdc_s & ~mdc_prev_q;

    // Management frame decoder
    pbmc_state_t state_q;
    logic [5:0]  pre_cnt_q;
    logic [3:0]  bit_cnt_q;
    logic [1:0]  op_q;
    logic [9:0]  addr_q;
    logic [15:0] shift_q;
    logic [15:0] wdata_q;
    logic        wr_q;
    logic        hit;
    logic [1:0]  op_next;

    assign hit     = (addr_q[9:5] == phy_addr_s) && (addr_q[4:0] == REG_BMC_ADDR);
    assign op_next = {op_q[0], mdio_s};

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_q   <= ST_PRE;
            pre_cnt_q <= 6'h00;
            bit_cnt_q <= 4'h0;
            op_q      <= 2'h0;
            addr_q    <= 10'h000;
            shift_q   <= 16'h0000;
            wdata_q   <= 16'h0000;
            wr_q      <= 1'b0;
        end else begin
            wr_q <= 1'b0;
            if (mdc_rise) begin
                unique case (state_q)
                    ST_PRE: begin
                        if (mdio_s) begin
                            if (pre_cnt_q != PRE_MIN) begin
                                pre_cnt_q <= pre_cnt_q + 6'h01;
                            end
                        end else begin
                            pre_cnt_q <= 6'h00;
                            if (pre_cnt_q == PRE_MIN) begin
                                state_q <= ST_START;
                            end
                        end
                    end
                    ST_START: begin
                        bit_cnt_q <= 4'h0;
                        state_q   <= mdio_s ? ST_OP : ST_PRE;
                    end
                    ST_OP: begin
                        op_q      <= op_next;
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                        if (bit_cnt_q == OP_LAST_BIT) begin
                            bit_cnt_q <= 4'h0;
                            state_q   <= (op_next == OP_WRITE || op_next == OP_READ)
                                         ? ST_ADDR : ST_PRE;
                        end
                    end
                    ST_ADDR: begin
                        addr_q    <= {addr_q[8:0], mdio_s};
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                        if (bit_cnt_q == ADDR_LAST_BIT) begin
                            bit_cnt_q <= 4'h0;
                            state_q   <= ST_TA;
                        end
                    end
                    ST_TA: begin
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                        if (bit_cnt_q == TA_LAST_BIT) begin
                            bit_cnt_q <= 4'h0;
                            state_q   <= ST_DATA;
                        end
                    end
                    ST_DATA: begin
                        shift_q   <= {shift_q[14:0], mdio_s};
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                        if (bit_cnt_q == DATA_LAST_BIT) begin
                            bit_cnt_q <= 4'h0;
                            state_q   <= ST_PRE;
                            wdata_q   <= {shift_q[14:0], mdio_s};
                            wr_q      <= (op_q == OP_WRITE) && hit;
                        end
                    end
                endcase
            end
        end
    end

    // Control fields
    logic load_pend_q;
    logic an_en_q;
    logic speed_q;
    logic duplex_q;
    logic pd_q;
    logic iso_q;
    logic restart_q;
    logic coltest_q;
    logic restart_set;
    logic [15:0] rd_word;

    // Straps are caught one edge after release, once the synchroniser is full
    always_ff @(posedge core_clk) begin
        if (rst) begin
            load_pend_q <= 1'b1;
            an_en_q     <= CTRL_RESET;
            speed_q     <= CTRL_RESET;
            duplex_q    <= CTRL_RESET;
        end else begin
            load_pend_q <= 1'b0;
            if (load_pend_q) begin
                an_en_q  <= an_strap_s;                // see (R1)
                speed_q  <= spd_strap_s;
                duplex_q <= dup_strap_s;
            end else if (wr_q) begin
                an_en_q  <= wdata_q[BIT_AN_EN];
                speed_q  <= wdata_q[BIT_SPEED];
                duplex_q <= wdata_q[BIT_DUPLEX];
            end
            if (fiber_s) begin
                an_en_q <= 1'b0;                       // see (R2)
            end
        end
    end

    // Pin assertion wins over a write of zero in the same cycle
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pd_q      <= CTRL_RESET;                   // see (R18)
            iso_q     <= CTRL_RESET;
            coltest_q <= CTRL_RESET;
        end else begin
            pd_q <= ~pd_n_s | (wr_q ? wdata_q[BIT_PWR_DOWN] : pd_q); // see (R8)
            if (wr_q) begin
                iso_q     <= wdata_q[BIT_ISOLATE];
                coltest_q <= wdata_q[BIT_COL_TEST];
            end
        end
    end

    // Written enable counts, so one write may enable and restart together
    assign restart_set = wr_q & wdata_q[BIT_RESTART] & wdata_q[BIT_AN_EN] & ~fiber_s; // see (R11)

    always_ff @(posedge core_clk) begin
        if (rst) begin
            restart_q <= CTRL_RESET;
        end else begin
            // Writing restart zero never clears a pending request; writing enable zero does
            restart_q <= restart_set | (restart_q & ~an_started & an_en_q); // see (R12) (R13)
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            mode <= '0;
        end else begin
            mode.an_enable   <= an_en_q;
            mode.speed_100   <= an_en_q ? an_speed_100 : speed_q;     // see (R3) (R4) (R5)
            mode.full_duplex <= an_en_q ? an_full_duplex : duplex_q;  // see (R4) (R14)
            mode.power_down  <= pd_q | ~pd_n_s;                       // see (R6) (R7)
            mode.isolate     <= iso_q;                                // see (R9)
            mode.restart_req <= restart_q;                            // see (R10)
        end
    end

    // Software reset and loopback are not held here and read as zero
    assign rd_word = hit ? {2'h0, speed_q, an_en_q, pd_q, iso_q, restart_q,
                            duplex_q, coltest_q, RSVD_VALUE} : 16'h0000; // see (R17)

    // Read data: drive turnaround zero, then sixteen bits, then release
    logic [15:0] rd_q;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            mdio_o  <= 1'b0;
            mdio_oe <= 1'b0;
            rd_q    <= 16'h0000;
        end else if (mdc_rise) begin
            if (state_q == ST_TA && op_q == OP_READ && (addr_q[9:5] == phy_addr_s)) begin
                mdio_oe <= 1'b1;
                if (bit_cnt_q == 4'h0) begin
                    mdio_o <= 1'b0;
                end else begin
                    mdio_o <= rd_word[15];
                    rd_q   <= {rd_word[14:0], 1'b0};
                end
            end else if (state_q == ST_DATA && mdio_oe) begin
                if (bit_cnt_q == DATA_LAST_BIT) begin
                    mdio_oe <= 1'b0;
                    mdio_o  <= 1'b0;
                end else begin
                    mdio_o <= rd_q[15];
                    rd_q   <= {rd_q[14:0], 1'b0};
                end
            end else begin
                mdio_oe <= 1'b0;
            end
        end
    end

    pbmc_col_test u_col (
        .core_clk (core_clk),
        .rst      (rst),
        .test_en  (coltest_q),
        .tx_en_s  (tx_en_s),
        .col      (col)
    );

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    property p_strap_load;
        // Reset is still sampled high on the release edge, fields are not loaded yet
        (load_pend_q && !rst) |=> an_en_q == ($past(an_strap_s) & ~$past(fiber_s));
    endproperty
    a_strap_load: assert property (p_strap_load) else $error("Strap not loaded"); // see (R1)

    property p_fiber_clear;
        fiber_s |=> !an_en_q ##1 !mode.an_enable;
    endproperty
    a_fiber_clear: assert property (p_fiber_clear) else $error("Fiber left AN on"); // see (R2)

    property p_an_mode;
        an_en_q |=> (mode.speed_100 == $past(an_speed_100))
                    && (mode.full_duplex == $past(an_full_duplex));
    endproperty
    a_an_mode: assert property (p_an_mode) else $error("AN mode not followed"); // see (R3)

    property p_forced_mode;
        !an_en_q |=> (mode.speed_100 == $past(speed_q))
                     && (mode.full_duplex == $past(duplex_q));
    endproperty
    a_forced_mode: assert property (p_forced_mode) else $error("Forced mode wrong"); // see (R4)

    property p_pd_or;
        (pd_q || !pd_n_s) |=> mode.power_down;
    endproperty
    a_pd_or: assert property (p_pd_or) else $error("Power down not ORed"); // see (R7)

    property p_pd_pin_sets;
        !pd_n_s |=> pd_q;
    endproperty
    a_pd_pin_sets: assert property (p_pd_pin_sets) else $error("Pin did not set field"); // see (R8)

    property p_restart_ignored;
        (!restart_q && !(wr_q && wdata_q[BIT_AN_EN])) |=> !restart_q;
    endproperty
    a_restart_ignored: assert property (p_restart_ignored) else $error("Restart taken"); // see (R11)

    property p_restart_hold;
        (restart_q && !an_started && an_en_q) |=> restart_q;
    endproperty
    a_restart_hold: assert property (p_restart_hold) else $error("Restart lost"); // see (R12)

    property p_restart_clear;
        (restart_q && an_started && !restart_set) |=> !restart_q ##1 !mode.restart_req;
    endproperty
    a_restart_clear: assert property (p_restart_clear) else $error("No self-clear"); // see (R12)

    property p_isolate;
        iso_q |=> mode.isolate;
    endproperty
    a_isolate: assert property (p_isolate) else $error("Isolate not driven"); // see (R9)

    property p_rsvd_zero;
        (mdc_rise && state_q == ST_TA && bit_cnt_q == TA_LAST_BIT) |-> rd_word[6:0] == 7'h00;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("Reserved bits nonzero"); // see (R17)

    property p_reset_zero;
        $fell(load_pend_q) |-> !iso_q && !coltest_q && !restart_q;
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("Bad reset value"); // see (R18)

endmodule : pbmc_top

// ### hdl/pbmc_pkg.sv
// Constants, states and carrier types of the basic mode control block.
// Assumes one 125 MHz core clock and a synchronous, active high reset.
// How it works
// (R1) Auto-negotiation enable loads from strap at reset
// (R2) Fiber mode forces auto-negotiation enable to zero
// (R3) Auto-negotiation on: speed and duplex fields ignored
// (R4) Auto-negotiation off: fields set speed and duplex
// (R5) Speed field one is 100, zero 10
// (R6) Power down field powers port down, registers live
// (R7) Power down field ORed with power-down pin
// (R8) Low power-down pin sets power down field
// (R9) Isolate field detaches port from MII data
// (R10) Writing restart one restarts auto-negotiation
// (R11) Restart ignored while auto-negotiation disabled
// (R12) Restart reads one until started, then clears
// (R13) Writing restart zero leaves negotiation unaffected
// (R14) Duplex field one full, zero half duplex
// (R15) Collision test: COL within 512 bits of TX_EN
// (R16) Collision test: COL drops within 4 bits
// (R17) Low seven bits ignore writes, read zero
// (R18) Power down, isolate, restart, collision test reset zero
package pbmc_pkg;

    localparam int unsigned CORE_CLK_NS     = 8;
    localparam int unsigned BIT_NS_100      = 10;
    localparam int unsigned COL_ON_BITS     = 512;
    localparam int unsigned COL_OFF_BITS    = 4;
    localparam int unsigned COL_ON_MAX_CYC  = COL_ON_BITS * BIT_NS_100 / CORE_CLK_NS;
    localparam int unsigned COL_OFF_MAX_CYC = COL_OFF_BITS * BIT_NS_100 / CORE_CLK_NS;

    localparam logic [4:0]  REG_BMC_ADDR  = 5'h00;
    localparam int unsigned BIT_SPEED     = 13;
    localparam int unsigned BIT_AN_EN     = 12;
    localparam int unsigned BIT_PWR_DOWN  = 11;
    localparam int unsigned BIT_ISOLATE   = 10;
    localparam int unsigned BIT_RESTART   = 9;
    localparam int unsigned BIT_DUPLEX    = 8;
    localparam int unsigned BIT_COL_TEST  = 7;
    localparam logic [6:0]  RSVD_VALUE    = 7'h00;
    localparam logic        CTRL_RESET    = 1'b0;

    localparam logic [5:0]  PRE_MIN       = 6'h20;
    localparam logic [1:0]  OP_WRITE      = 2'h1;
    localparam logic [1:0]  OP_READ       = 2'h2;
    localparam logic [3:0]  OP_LAST_BIT   = 4'h1;
    localparam logic [3:0]  ADDR_LAST_BIT = 4'h9;
    localparam logic [3:0]  TA_LAST_BIT   = 4'h1;
    localparam logic [3:0]  DATA_LAST_BIT = 4'hf;

    typedef enum logic [5:0] {
        ST_PRE   = 6'h01,
        ST_START = 6'h02,
        ST_OP    = 6'h04,
        ST_ADDR  = 6'h08,
        ST_TA    = 6'h10,
        ST_DATA  = 6'h20
    } pbmc_state_t;

    typedef struct packed {
        logic an_enable;
        logic speed_100;
        logic full_duplex;
        logic power_down;
        logic isolate;
        logic restart_req;
    } pbmc_mode_t;

endpackage : pbmc_pkg

// ### hdl/pbmc_sync.sv
// Two-flop synchroniser for a vector of unrelated pin levels.
// Assumes each bit is a slow level; bits are not coherent with each other.
`timescale 1ns/1ps
module pbmc_sync #(
    parameter int W = 13
) (
    input  wire logic         core_clk, // Core clock
    input  wire logic [W-1:0] d,        // Asynchronous pin levels
    output logic      [W-1:0] q         // Synchronised levels
);
    import pbmc_pkg::*;

    logic [W-1:0] meta_q;

    // No reset: the reset is held long enough to flush both stages
    always_ff @(posedge core_clk) begin
        meta_q <= d;
        q      <= meta_q;
    end

endmodule : pbmc_sync

// ### hdl/pbmc_col_test.sv
// Collision test generator: echoes transmit enable onto COL.
// Assumes tx_en_s is already synchronised to core_clk.
`timescale 1ns/1ps
module pbmc_col_test (
    input  wire logic core_clk, // Core clock
    input  wire logic rst,      // Synchronous reset
    input  wire logic test_en,  // Collision test field
    input  wire logic tx_en_s,  // Synchronised transmit enable
    output logic      col       // Collision indication
);
    import pbmc_pkg::*;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            col <= 1'b0;
        end else begin
            col <= test_en & tx_en_s; // see (R15) (R16)
        end
    end

    property p_col_on;
        @(posedge core_clk) disable iff (rst)
        (test_en && tx_en_s) |=> col;
    endproperty
    a_col_on: assert property (p_col_on) else $error("COL missed TX_EN in test"); // see (R15)

    property p_col_off;
        @(posedge core_clk) disable iff (rst)
        $fell(tx_en_s) |=> !col;
    endproperty
    a_col_off: assert property (p_col_off) else $error("COL held after TX_EN"); // see (R16)

endmodule : pbmc_col_test

// ### verification/pbmc_mac_model.sv
// MAC station management model: drives MDC and MDIO frames to the port.
// Assumes the port syncs MDC/MDIO to core_clk; the MDIO wire has a pull-up.
`timescale 1ns/1ps
module pbmc_mac_model
    import pbmc_pkg::*;
(
    input  wire logic core_clk,  // Core clock
    input  wire logic mdio_o,    // Port data out
    input  wire logic mdio_oe,   // Port drive enable
    output logic      mdc,       // Management clock, still between frames
    output logic      mdio_line  // Resolved MDIO wire level
);
    // Six cycles per phase keeps MDC below 12.5 MHz
    localparam int HALF = 6;
    logic mac_d;
    logic mac_oe;

    initial begin
        mdc    = 1'b0;
        mac_d  = 1'b1;
        mac_oe = 1'b0;
    end

    // Released wire floats to the pull-up level, never the stale value
    assign mdio_line = mdio_oe ? mdio_o : (mac_oe ? mac_d : 1'b1);

    // One MDC period; s is the wire level seen at the rising edge
    task automatic clk_bit(input logic b, input logic drv, output logic s);
        @(posedge core_clk);
        mac_d  <= b;
        mac_oe <= drv;
        repeat (HALF - 1) @(posedge core_clk);
        s = mdio_line;
        mdc <= 1'b1;
        repeat (HALF) @(posedge core_clk);
        mdc <= 1'b0;
    endtask : clk_bit

    task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                         input logic [15:0] wd, output logic [15:0] rd);
        logic        s;
        logic        wr;
        logic [13:0] hdr;
        wr  = (op == OP_WRITE);
        hdr = {2'b01, op, pa, ra};
        for (int i = 0; i < 32; i++) clk_bit(1'b1, 1'b1, s);
        for (int i = 13; i >= 0; i--) clk_bit(hdr[i], 1'b1, s);
        clk_bit(1'b1, wr, s);
        clk_bit(1'b0, wr, s);
        for (int i = 15; i >= 0; i--) begin
            clk_bit(wd[i], wr, s);
            rd[i] = s;
        end
        mac_oe <= 1'b0;
    endtask : frame
endmodule : pbmc_mac_model

// ### verification/tb_top.sv
// Self-checking bench for the basic mode control register block.
// Assumes the MAC model for register access; bench plays the AN engine.
`timescale 1ns/1ps
`define CHK(got, exp) \
    begin \
        n_tests++; \
        if ((got) !== (exp)) begin \
            err_total++; \
            $display("ERROR t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
        end \
    end
module tb_top
    import pbmc_pkg::*;
;
    localparam logic [4:0] PHY = 5'h03;
    logic       core_clk = 1'b0;
    logic       rst      = 1'b1;
    logic       mdc;
    logic       mdio_line;
    logic       mdio_o;
    logic       mdio_oe;
    logic       an_strap = 1'b1;
    logic       fiber    = 1'b0;
    logic       pd_n     = 1'b1;
    logic       tx_en    = 1'b0;
    logic       col;
    logic       an_spd   = 1'b0;
    logic       an_fdx   = 1'b1;
    logic       an_start = 1'b0;
    pbmc_mode_t mode_w;
    int         err_total = 0;
    int         n_tests   = 0;

    always #4 core_clk = ~core_clk;

    pbmc_top i_pbmc_top (
        .core_clk(core_clk), .rst(rst), .mdc(mdc), .mdio_i(mdio_line),
        .mdio_o(mdio_o), .mdio_oe(mdio_oe), .phy_addr_pin(PHY),
        .an_enable_strap(an_strap), .speed_strap(1'b1), .duplex_strap(1'b0),
        .fiber_mode_enable(fiber), .power_down_input_pin_n(pd_n), .tx_en(tx_en),
        .col(col), .an_speed_100(an_spd), .an_full_duplex(an_fdx),
        .an_started(an_start), .mode(mode_w)
    );

    pbmc_mac_model i_pbmc_mac_model (
        .core_clk(core_clk), .mdio_o(mdio_o), .mdio_oe(mdio_oe),
        .mdc(mdc), .mdio_line(mdio_line)
    );

    task automatic wr(input logic [15:0] d);
        logic [15:0] r;
        i_pbmc_mac_model.frame(OP_WRITE, PHY, REG_BMC_ADDR, d, r);
        repeat (4) @(posedge core_clk);
    endtask : wr

    task automatic rd(input logic [4:0] pa, input logic [4:0] ra, output logic [15:0] d);
        i_pbmc_mac_model.frame(OP_READ, pa, ra, 16'hffff, d);
    endtask : rd

    task automatic results;
        $display("Checks %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : results

    initial begin
        // About 32 frames of 770 cycles each, with margin
        repeat (60000) @(posedge core_clk);
        err_total++;
        results();
    end

    initial begin
        logic [15:0] r;
        logic        s;
        logic        d;
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        repeat (4) @(posedge core_clk);
        // Reset state, unmapped register and foreign address
        rd(PHY, REG_BMC_ADDR, r);
        `CHK(r, 16'h3000)
        `CHK(mode_w, 6'h28)
        rd(PHY, 5'h01, r);
        `CHK(r, 16'h0000)
        rd(5'h04, REG_BMC_ADDR, r);
        `CHK(r, 16'hffff)
        $display("test reset done");
        // Forced speed and duplex; reserved bits written with ones
        for (int i = 0; i < 4; i++) begin
            s = i[1];
            d = i[0];
            wr({2'h3, s, 1'b0, 3'h0, d, 1'b0, 7'h7f});
            rd(PHY, REG_BMC_ADDR, r);
            `CHK(r, {2'h0, s, 1'b0, 3'h0, d, 8'h00})
            `CHK(mode_w.speed_100, s)
            `CHK(mode_w.full_duplex, d)
        end
        wr(16'h3000);
        `CHK(mode_w.speed_100, 1'b0)
        `CHK(mode_w.full_duplex, 1'b1)
        @(posedge core_clk);
        an_spd <= 1'b1;
        an_fdx <= 1'b0;
        repeat (3) @(posedge core_clk);
        `CHK(mode_w.speed_100, 1'b1)
        `CHK(mode_w.full_duplex, 1'b0)
        $display("test speed duplex done");
        // Power down by field and by pin
        wr(16'h0800);
        rd(PHY, REG_BMC_ADDR, r);
        `CHK(r, 16'h0800)
        `CHK(mode_w.power_down, 1'b1)
        wr(16'h0000);
        `CHK(mode_w.power_down, 1'b0)
        @(posedge core_clk);
        pd_n <= 1'b0;
        repeat (6) @(posedge core_clk);
        `CHK(mode_w.power_down, 1'b1)
        wr(16'h0000);
        rd(PHY, REG_BMC_ADDR, r);
        `CHK(r, 16'h0800)
        pd_n <= 1'b1;
        wr(16'h0000);
        rd(PHY, REG_BMC_ADDR, r);
        `CHK(r, 16'h0000)
        `CHK(mode_w.power_down, 1'b0)
        $display("test power down done");
        wr(16'h0400);
        rd(PHY, REG_BMC_ADDR, r);
        `CHK(r, 16'h0400)
        `CHK(mode_w.isolate, 1'b1)
        wr(16'h0000);
        `CHK(mode_w.isolate, 1'b0)
        $display("test isolate done");
        // Restart: ignored with AN off, held until the engine starts
        wr(16'h0200);
        rd(PHY, REG_BMC_ADDR, r);
        `CHK(r, 16'h0000)
        `CHK(mode_w.restart_req, 1'b0)
        wr(16'h1200);
        `CHK(mode_w.restart_req, 1'b1)
        wr(16'h1000);
        rd(PHY, REG_BMC_ADDR, r);
        `CHK(r, 16'h1200)
        `CHK(mode_w.restart_req, 1'b1)
        @(posedge core_clk);
        an_start <= 1'b1;
        @(posedge core_clk);
        an_start <= 1'b0;
        repeat (3) @(posedge core_clk);
        `CHK(mode_w.restart_req, 1'b0)
        rd(PHY, REG_BMC_ADDR, r);
        `CHK(r, 16'h1000)
        $display("test restart done");
        @(posedge core_clk);
        fiber <= 1'b1;
        repeat (6) @(posedge core_clk);
        wr(16'h1000);
        rd(PHY, REG_BMC_ADDR, r);
        `CHK(r, 16'h0000)
        `CHK(mode_w.an_enable, 1'b0)
        fiber <= 1'b0;
        $display("test fiber done");
        // Collision test on and off
        wr(16'h0080);
        @(posedge core_clk);
        tx_en <= 1'b1;
        repeat (COL_ON_MAX_CYC) @(posedge core_clk);
        `CHK(col, 1'b1)
        tx_en <= 1'b0;
        repeat (COL_OFF_MAX_CYC) @(posedge core_clk);
        `CHK(col, 1'b0)
        wr(16'h0000);
        tx_en <= 1'b1;
        repeat (10) @(posedge core_clk);
        `CHK(col, 1'b0)
        tx_en <= 1'b0;
        $display("test collision done");
        results();
    end
endmodule : tb_top
